// ==== logic/nvc_pkg.sv ====
// package: register map, fields and timing for the nonvolatile control block
`default_nettype none
package nvc_pkg;
	localparam logic [11:0] ctrl_offset     = 12'h000;
	localparam logic [11:0] key_offset      = 12'h004;
	localparam logic [11:0] addr_offset     = 12'h008;
	localparam logic [11:0] rdata_offset    = 12'h00c;
	localparam logic [11:0] wdata_offset    = 12'h010;
	localparam logic [11:0] eedata_offset   = 12'h014;
	localparam logic [7:0]  key_first       = 8'h55;
	localparam logic [7:0]  key_second      = 8'haa;
	localparam int          start_bit       = 15;
	localparam int          wren_bit        = 14;
	localparam int          err_bit         = 13;
	localparam int          pgmonly_bit     = 12;
	localparam int          erase_bit       = 6;
	localparam logic [15:0] ctrl_write_mask = 16'h707f;
	localparam logic [15:0] ctrl_reset      = 16'h0000;
	localparam logic [5:0]  op_word_program = 6'h03;
	localparam logic [5:0]  op_ee_word      = 6'h04;
	localparam logic [23:0] ee_base         = 24'h7ffe00;
	localparam logic [23:0] ee_top          = 24'h7fffff;
	localparam int          ee_words        = 256;
	localparam int          clk_mhz         = 100;
	localparam int          op_time_us      = 4;
	localparam int          op_cycles       = op_time_us * clk_mhz;
	localparam logic [15:0] op_cycles_w     = 16'(op_cycles);
	localparam logic [23:0] addr_reset      = 24'h000000;
endpackage : nvc_pkg
`default_nettype wire

// ==== logic/nvc_unlock_ctrl.sv ====
// nonvolatile unlock logic, control registers and data eeprom array on apb
//
// Implementation choices: the APB slave port and the placing of the registers.
`default_nettype none

module nvc_unlock_ctrl (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             flash_prog_start,
	output logic      [23:0] flash_prog_addr,
	output logic      [15:0] flash_prog_data
);

	typedef enum logic [1:0] {locked, got_first, armed} nvc_lock_type;
	typedef enum logic [1:0] {idle, busy} nvc_op_type;

	nvc_lock_type lock_state;
	nvc_op_type   op_state;
	logic [15:0] ctrl;
	logic [23:0] target_addr;
	logic [15:0] wdata_hold;
	logic [15:0] ee_rdata;
	logic [15:0] op_count;
	logic [15:0] ee_mem [nvc_pkg::ee_words];

	logic        wr_acc;
	logic        rd_acc;
	logic        key_wr;
	logic        ctrl_wr;
	logic        ctrl_take;
	logic        start_req;
	logic        addr_in_ee;
	logic [7:0]  ee_index;
	logic        op_done;
	logic        known_addr;

	function automatic logic in_ee(input logic [23:0] a);
		in_ee = (a >= nvc_pkg::ee_base) && (a <= nvc_pkg::ee_top);
	endfunction

	function automatic logic [7:0] ee_word(input logic [23:0] a);
		logic [23:0] off;
		off = a - nvc_pkg::ee_base;
		ee_word = off[8:1];
	endfunction

	assign wr_acc     = psel && penable && pwrite;
	assign rd_acc     = psel && penable && !pwrite;
	assign key_wr     = wr_acc && (paddr == nvc_pkg::key_offset);
	assign ctrl_wr    = wr_acc && (paddr == nvc_pkg::ctrl_offset);
	assign ctrl_take  = ctrl_wr && (lock_state == armed);
	assign start_req  = ctrl_take && pwdata[nvc_pkg::start_bit] && (op_state == idle);
	assign addr_in_ee = in_ee(target_addr);
	assign ee_index   = ee_word(target_addr);
	assign op_done    = (op_state == busy) && (op_count == 16'h0001);
	assign known_addr = (paddr == nvc_pkg::ctrl_offset) || (paddr == nvc_pkg::key_offset)
		|| (paddr == nvc_pkg::addr_offset) || (paddr == nvc_pkg::rdata_offset)
		|| (paddr == nvc_pkg::wdata_offset) || (paddr == nvc_pkg::eedata_offset);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= psel && !penable && (paddr[11:2] > nvc_pkg::eedata_offset[11:2]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_state <= locked;
		end else if (wr_acc && pready) begin
			unique case (lock_state)
				locked: begin
					if (key_wr && pwdata[7:0] == nvc_pkg::key_first) begin
						lock_state <= got_first;
					end
				end
				got_first: begin
					if (key_wr && pwdata[7:0] == nvc_pkg::key_second) begin
						lock_state <= armed;
					end else if (key_wr && pwdata[7:0] == nvc_pkg::key_first) begin
						lock_state <= got_first;
					end else begin
						lock_state <= locked;
					end
				end
				armed: begin
					lock_state <= locked;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= nvc_pkg::ctrl_reset;
		end else begin
			if (ctrl_take && pready) begin
				ctrl <= (pwdata[15:0] & nvc_pkg::ctrl_write_mask) | (ctrl & ~nvc_pkg::ctrl_write_mask);
			end
			if (start_req && pready && pwdata[nvc_pkg::wren_bit]) begin
				ctrl[nvc_pkg::start_bit] <= 1'b1;
				ctrl[nvc_pkg::err_bit]   <= 1'b0;
			end else if (start_req && pready) begin
				ctrl[nvc_pkg::err_bit] <= 1'b1;
			end else if (op_done) begin
				ctrl[nvc_pkg::start_bit] <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_state <= idle;
			op_count <= 16'h0000;
		end else if (start_req && pready && pwdata[nvc_pkg::wren_bit]) begin
			op_state <= busy;
			op_count <= nvc_pkg::op_cycles_w;
		end else if (op_done) begin
			op_state <= idle;
			op_count <= 16'h0000;
		end else if (op_state == busy) begin
			op_count <= op_count - 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			target_addr <= nvc_pkg::addr_reset;
		end else if (wr_acc && pready && paddr == nvc_pkg::addr_offset) begin
			target_addr <= pwdata[23:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdata_hold <= 16'h0000;
		end else if (wr_acc && pready && paddr == nvc_pkg::wdata_offset) begin
			wdata_hold <= pwdata[15:0];
		end
	end

	always_ff @(posedge pclk) begin
		if (op_done && addr_in_ee && ctrl[5:0] == nvc_pkg::op_ee_word) begin
			ee_mem[ee_index] <= ctrl[nvc_pkg::erase_bit] ? 16'hffff : wdata_hold;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ee_rdata <= 16'h0000;
		end else if (addr_in_ee) begin
			ee_rdata <= ee_mem[ee_index];
		end else begin
			ee_rdata <= 16'h0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_prog_start <= 1'b0;
			flash_prog_addr  <= nvc_pkg::addr_reset;
			flash_prog_data  <= 16'h0000;
		end else begin
			flash_prog_start <= start_req && pready && pwdata[nvc_pkg::wren_bit]
				&& pwdata[5:0] == nvc_pkg::op_word_program && !addr_in_ee;
			if (start_req && pready) begin
				flash_prog_addr <= target_addr;
				flash_prog_data <= wdata_hold;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite && known_addr) begin
			unique case (paddr)
				nvc_pkg::ctrl_offset:   prdata <= {16'h0000, ctrl};
				nvc_pkg::addr_offset:   prdata <= {8'h00, target_addr};
				nvc_pkg::wdata_offset:  prdata <= {16'h0000, wdata_hold};
				nvc_pkg::eedata_offset: prdata <= {16'h0000, ee_rdata};
				nvc_pkg::rdata_offset:  prdata <= {16'h0000, ee_rdata};
				default:                prdata <= 32'h00000000;
			endcase
		end else if (psel && !penable) begin
			prdata <= 32'h00000000;
		end
	end

	sequence s_key_pair;
		key_wr && pready && pwdata[7:0] == nvc_pkg::key_first
		##[1:8] key_wr && pready && pwdata[7:0] == nvc_pkg::key_second && lock_state == got_first;
	endsequence

	AST_ARMED_AFTER_PAIR: assert property (@(posedge pclk) disable iff (!presetn)
		s_key_pair |=> lock_state == armed)
		else $error("key pair did not arm");
	AST_CTRL_LOCKED: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_wr && pready && lock_state != armed |=> $stable(ctrl[nvc_pkg::erase_bit:0]))
		else $error("control changed while locked");
	AST_WINDOW_ONE: assert property (@(posedge pclk) disable iff (!presetn)
		wr_acc && pready && lock_state == armed |=> lock_state == locked)
		else $error("window lasted beyond one write");
	AST_START_SETS: assert property (@(posedge pclk) disable iff (!presetn)
		start_req && pready && pwdata[nvc_pkg::wren_bit] |=> ctrl[nvc_pkg::start_bit] && op_state == busy)
		else $error("start did not begin operation");
	AST_START_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
		op_done |=> !ctrl[nvc_pkg::start_bit])
		else $error("start bit not cleared on completion");
	AST_START_HELD: assert property (@(posedge pclk) disable iff (!presetn)
		op_state == busy |-> ctrl[nvc_pkg::start_bit])
		else $error("start bit dropped while busy");
	AST_BAD_KEY: assert property (@(posedge pclk) disable iff (!presetn)
		lock_state == got_first && wr_acc && pready && !key_wr |=> lock_state == locked)
		else $error("intervening write did not relock");
	AST_NO_STALL: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready)
		else $error("bus stalled");
	AST_KEY_READ_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && paddr == nvc_pkg::key_offset |=> prdata == 32'h00000000)
		else $error("key register readable");

	sequence s_ee_store_done;
		op_done && addr_in_ee && ctrl[5:0] == nvc_pkg::op_ee_word
		##1 $stable(target_addr);
	endsequence

	AST_KEY_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
		lock_state == locked && key_wr && pready && pwdata[7:0] == nvc_pkg::key_first |=> lock_state == got_first)
		else $error("first key not taken");
	AST_ERR_NO_ENABLE: assert property (@(posedge pclk) disable iff (!presetn)
		start_req && pready && !pwdata[nvc_pkg::wren_bit] |=> ctrl[nvc_pkg::err_bit] && !ctrl[nvc_pkg::start_bit])
		else $error("start without enable did not flag error");
	AST_FLASH_START: assert property (@(posedge pclk) disable iff (!presetn)
		start_req && pready && pwdata[nvc_pkg::wren_bit] && pwdata[5:0] == nvc_pkg::op_word_program && !addr_in_ee
		|=> flash_prog_start && flash_prog_addr == $past(target_addr) && flash_prog_data == $past(wdata_hold))
		else $error("flash word program not started");
	AST_FLASH_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
		flash_prog_start |=> !flash_prog_start)
		else $error("flash start longer than one cycle");
	AST_EE_WORD_STORED: assert property (@(posedge pclk) disable iff (!presetn)
		s_ee_store_done |=> ee_rdata == ($past(ctrl[nvc_pkg::erase_bit], 2) ? 16'hffff : $past(wdata_hold, 2)))
		else $error("eeprom word not stored");
	AST_EE_OUTSIDE_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		!addr_in_ee |=> ee_rdata == 16'h0000)
		else $error("eeprom data outside its window");
	AST_LOW_BYTE_TAKEN: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_take && pready && !pwdata[nvc_pkg::start_bit]
		|=> ctrl[nvc_pkg::erase_bit:0] == $past(pwdata[nvc_pkg::erase_bit:0]))
		else $error("operation select not taken in window");
	AST_ADDR_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
		wr_acc && pready && paddr == nvc_pkg::addr_offset |=> target_addr == $past(pwdata[23:0]))
		else $error("target address not loaded");

endmodule // nvc_unlock_ctrl
`default_nettype wire

// ==== test/tb.sv ====
// self-checking testbench for the nonvolatile unlock and control block
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        flash_prog_start;
	logic [23:0] flash_prog_addr;
	logic [15:0] flash_prog_data;
	logic [31:0] rd;
	logic        err;
	logic [23:0] st_addr;
	logic [15:0] st_data;
	int          errors;
	int          n_checks;
	int          n_starts;
	int          cyc;

	nvc_unlock_ctrl nvc_unlock_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.flash_prog_start(flash_prog_start), .flash_prog_addr(flash_prog_addr), .flash_prog_data(flash_prog_data));

	always #5 pclk = ~pclk;

	// count start pulses and keep what they carried
	always @(posedge pclk) begin
		cyc++;
		if (flash_prog_start === 1'b1) begin
			n_starts++;
			st_addr = flash_prog_addr;
			st_data = flash_prog_data;
		end
	end

	task conclude;
		$display("errors %0d checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer, held until pready is sampled high
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 16) begin
			errors++;
			conclude();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task rchk(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task unlock;
		wr(nvc_pkg::key_offset, 32'h0000_0055);
		wr(nvc_pkg::key_offset, 32'h0000_00aa);
	endtask

	// poll the start bit; it must clear, and not before the operation time
	task wait_done(input int t0);
		int k;
		for (k = 0; k < 200; k++) begin
			xfer(1'b0, nvc_pkg::ctrl_offset, 32'h0);
			if (rd[15] === 1'b0)
				break;
		end
		chk(32'(k < 200), 32'h1);
		chk(32'(cyc - t0 >= nvc_pkg::op_cycles), 32'h1);
		if (k == 200)
			conclude();
	endtask

	task t_locked;
		chk({31'h0, flash_prog_start}, 32'h0);
		rchk(nvc_pkg::ctrl_offset, 32'h0);
		wr(nvc_pkg::key_offset, 32'h0000_0055);
		rchk(nvc_pkg::key_offset, 32'h0);
		wr(nvc_pkg::ctrl_offset, 32'h0000_4003);
		rchk(nvc_pkg::ctrl_offset, 32'h0);
		xfer(1'b0, 12'h018, 32'h0);
		chk({31'h0, err}, 32'h1);
	endtask

	task t_window;
		unlock();
		wr(nvc_pkg::ctrl_offset, 32'h0000_4003);
		rchk(nvc_pkg::ctrl_offset, 32'h0000_4003);
		wr(nvc_pkg::ctrl_offset, 32'h0000_0004);
		rchk(nvc_pkg::ctrl_offset, 32'h0000_4003);
	endtask

	task t_relock;
		wr(nvc_pkg::key_offset, 32'h0000_0055);
		wr(nvc_pkg::addr_offset, 32'h0000_0100);
		wr(nvc_pkg::key_offset, 32'h0000_00aa);
		wr(nvc_pkg::ctrl_offset, 32'h0000_0004);
		rchk(nvc_pkg::ctrl_offset, 32'h0000_4003);
		wr(nvc_pkg::key_offset, 32'h0000_0055);
		wr(nvc_pkg::key_offset, 32'h0000_0011);
		wr(nvc_pkg::key_offset, 32'h0000_00aa);
		wr(nvc_pkg::ctrl_offset, 32'h0000_0004);
		rchk(nvc_pkg::ctrl_offset, 32'h0000_4003);
	endtask

	task t_flash;
		int t0;
		wr(nvc_pkg::addr_offset, 32'h0000_1234);
		wr(nvc_pkg::wdata_offset, 32'h0000_beef);
		unlock();
		wr(nvc_pkg::ctrl_offset, 32'h0000_c003);
		t0 = cyc;
		repeat (2) @(posedge pclk);
		xfer(1'b0, nvc_pkg::ctrl_offset, 32'h0);
		chk({31'h0, rd[15]}, 32'h1);
		chk(n_starts, 1);
		chk({8'h0, st_addr}, 32'h0000_1234);
		chk({16'h0, st_data}, 32'h0000_beef);
		wait_done(t0);
	endtask

	task ee_store(input logic [23:0] a, input logic [15:0] d, input logic [31:0] op);
		int t0;
		wr(nvc_pkg::addr_offset, {8'h0, a});
		wr(nvc_pkg::wdata_offset, {16'h0, d});
		unlock();
		wr(nvc_pkg::ctrl_offset, op);
		t0 = cyc;
		repeat (2) @(posedge pclk);
		xfer(1'b0, nvc_pkg::ctrl_offset, 32'h0);
		chk({31'h0, err}, 32'h0);
		chk({31'h0, rd[15]}, 32'h1);
		wait_done(t0);
	endtask

	task t_eeprom;
		ee_store(24'h7ffffe, 16'ha5c3, 32'h0000_c004);
		ee_store(24'h7ffe00, 16'h0f0f, 32'h0000_c004);
		chk(n_starts, 1);
		rchk(nvc_pkg::eedata_offset, 32'h0000_0f0f);
		wr(nvc_pkg::addr_offset, 32'h007f_fffe);
		rchk(nvc_pkg::eedata_offset, 32'h0000_a5c3);
	endtask

	task t_erase;
		ee_store(24'h7ffe00, 16'h1234, 32'h0000_c044);
		rchk(nvc_pkg::eedata_offset, 32'h0000_ffff);
	endtask

	task t_errflag;
		unlock();
		wr(nvc_pkg::ctrl_offset, 32'h0000_8004);
		rchk(nvc_pkg::ctrl_offset, 32'h0000_2004);
	endtask

	task t_reset;
		unlock();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		chk({29'h0, pready, pslverr, flash_prog_start}, 32'h0);
		wr(nvc_pkg::ctrl_offset, 32'h0000_4003);
		rchk(nvc_pkg::ctrl_offset, 32'h0);
		rchk(nvc_pkg::addr_offset, 32'h0);
		rchk(nvc_pkg::eedata_offset, 32'h0);
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_locked();
		t_window();
		t_relock();
		t_flash();
		t_eeprom();
		t_erase();
		t_errflag();
		t_reset();
		conclude();
	end
endmodule // tb
`default_nettype wire
